// >>> core/drgc_pkg.sv
// constants, register map and lookup tables for the stereo gain control stage
package drgc_pkg;
  localparam int CLK_NS = 5;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PATH_STATUS = 14'h0e01;
  localparam logic [13:0] IDX_DETECT_CFG = 14'h0e80;
  localparam logic [13:0] IDX_TIMING = 14'h0e81;
  localparam logic [13:0] IDX_GATE_RELEASE = 14'h0e82;
  localparam logic [15:0] DETECT_CFG_RST = 16'h0018;
  localparam logic [15:0] TIMING_RST = 16'h0933;
  localparam logic [15:0] GATE_RELEASE_RST = 16'h0000;
  // range_ctrl_detect_config fields
  localparam int CFG_RMS_THR_LSB = 11;
  localparam int CFG_PK_THR_LSB = 9;
  localparam int CFG_GATE_EN = 8;
  localparam int CFG_DET_SEL = 7;
  localparam int CFG_DET_EN = 6;
  localparam int CFG_KNEE2_EN = 5;
  localparam int CFG_FR_EN = 4;
  localparam int CFG_CLIP_EN = 3;
  localparam int CFG_SEQ_EN = 2;
  localparam int CFG_EN_LEFT = 1;
  localparam int CFG_EN_RIGHT = 0;
  // range_ctrl_timing_limits fields
  localparam int TIM_ATK_LSB = 9;
  localparam int TIM_DCY_LSB = 5;
  localparam int TIM_MIN_LSB = 2;
  localparam int TIM_MAX_LSB = 0;
  // gate and fast release fields
  localparam int GR_GATE_MIN_LSB = 12;
  localparam int GR_FR_THR_LSB = 8;
  localparam int GR_FR_RATE_LSB = 6;
  // effects_path_status bit positions
  localparam int STS_LEFT_BIT = 8;
  localparam int STS_RIGHT_BIT = 9;
  // rate times per 6dB in ns, gain moves in 0.75dB units
  localparam int ATTACK_BASE_NS = 181000;
  localparam int DECAY_BASE_NS = 1450000;
  localparam int FR_BASE_NS = 725000;
  localparam int UNITS_PER_6DB = 8;
  localparam int ATK_STEP_CYC = ATTACK_BASE_NS / (CLK_NS * UNITS_PER_6DB);
  localparam int DCY_STEP_CYC = DECAY_BASE_NS / (CLK_NS * UNITS_PER_6DB);
  localparam int FR_STEP_CYC = FR_BASE_NS / (CLK_NS * UNITS_PER_6DB);
  localparam logic [3:0] ATK_CODE_MIN = 4'h1;
  localparam logic [3:0] ATK_CODE_MAX = 4'hb;
  localparam logic [3:0] DCY_CODE_MAX = 4'hb;
  localparam int CLIP_SHIFT = 3;
  localparam int LOOKAHEAD = 4;
  localparam int RMS_SHIFT = 6;
  localparam int PEAK_SHIFT = 8;
  localparam int MANT_FRAC = 14;
  // levels as attenuation below full scale in 0.75dB units
  localparam logic signed [8:0] TARGET_ATT = 9'sh010;
  localparam logic [7:0] GATE_ATT = 8'h30;
  localparam logic [7:0] RMS_DET_BASE = 8'h28;
  localparam logic signed [8:0] CREST_BASE = 9'sh010;
  localparam logic signed [8:0] GATE_MIN_BASE = -9'sh030;
  localparam logic signed [8:0] GAIN_CAP = 9'sh030;
  localparam logic signed [8:0] COMP_MIN_UNITS [8] = '{9'sh000, -9'sh010, -9'sh018, -9'sh020,
                                                       -9'sh030, -9'sh030, -9'sh030, -9'sh030};
  localparam logic signed [8:0] MAX_UNITS [4] = '{9'sh010, 9'sh018, 9'sh020, 9'sh030};
  // 2^(k/8) in Q1.14
  localparam logic [14:0] MANT [8] = '{15'h4000, 15'h45cb, 15'h4c1c, 15'h52ff,
                                       15'h5a82, 15'h62b3, 15'h6ba2, 15'h7560};
endpackage

// >>> core/drgc_dynamic_range_gain_control.sv
// stereo dynamic range gain control stage with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module drgc_dynamic_range_gain_control #(
  parameter int unsigned ATK_STEP_CYC = drgc_pkg::ATK_STEP_CYC,
  parameter int unsigned DCY_STEP_CYC = drgc_pkg::DCY_STEP_CYC,
  parameter int unsigned FR_STEP_CYC = drgc_pkg::FR_STEP_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic IN_VALID,
  input wire logic signed [23:0] IN_LEFT,
  input wire logic signed [23:0] IN_RIGHT,
  output logic OUT_VALID,
  output logic signed [23:0] OUT_LEFT,
  output logic signed [23:0] OUT_RIGHT,
  output logic [1:0] ACTIVITY,
  output logic [1:0] CLIP_GUARD,
  output logic [1:0] DECAY,
  output logic [1:0] GATE,
  output logic [1:0] FAST_RELEASE,
  output logic SEQ_TRIGGER
);

  // {inverted msb position, inverted next three bits}: 8 units per octave
  function automatic logic [7:0] att_code(input logic [31:0] v);
    logic [4:0] p;
    logic [31:0] s;
    p = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    s = v << (5'h1f - p);
    return {~p, ~s[30:28]};
  endfunction

  // 12, 18, 24, 30 dB crest factor in 0.75dB units
  function automatic logic signed [8:0] crest_units(input logic [1:0] c);
    return $signed({4'h0, c, 3'h0}) + drgc_pkg::CREST_BASE;
  endfunction

  function automatic logic signed [8:0] clamp9(input logic signed [8:0] v, input logic signed [8:0] lo,
                                               input logic signed [8:0] hi);
    logic signed [8:0] r;
    r = (v < lo) ? lo : v;
    return (r > hi) ? hi : r;
  endfunction

  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // register slave: one wait state, then the access completes
  logic [15:0] detect_cfg_reg;
  logic [15:0] timing_reg;
  logic [15:0] gate_release_reg;
  logic [31:0] readdata_reg;
  logic ack_reg;
  logic req;
  logic [13:0] idx;
  logic hit_cfg;
  logic hit_tim;
  logic hit_gr;
  logic hit_sts;
  logic wr_now;
  logic [15:0] path_status;
  logic [15:0] rd_value;
  logic [15:0] be_mask;

  assign req = AVS_READ | AVS_WRITE;
  assign idx = AVS_ADDRESS[15:2];
  assign hit_cfg = idx == drgc_pkg::IDX_DETECT_CFG;
  assign hit_tim = idx == drgc_pkg::IDX_TIMING;
  assign hit_gr = idx == drgc_pkg::IDX_GATE_RELEASE;
  assign hit_sts = idx == drgc_pkg::IDX_PATH_STATUS;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign wr_now = AVS_WRITE & ack_reg;
  assign be_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign AVS_READDATA = readdata_reg;

  logic en_l;
  logic en_r;
  assign en_l = detect_cfg_reg[drgc_pkg::CFG_EN_LEFT];
  assign en_r = detect_cfg_reg[drgc_pkg::CFG_EN_RIGHT];
  assign path_status = (16'(en_r) << drgc_pkg::STS_RIGHT_BIT) | (16'(en_l) << drgc_pkg::STS_LEFT_BIT);
  assign rd_value = hit_sts ? path_status :
                    hit_cfg ? detect_cfg_reg :
                    hit_tim ? timing_reg :
                    hit_gr ? gate_release_reg : 16'h0000;

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (AVS_READ && !ack_reg) begin
        readdata_reg <= {16'h0000, rd_value};
      end
    end
  end

  // byte lane merge keeps gate_en and its neighbour activity_detect_sel independent
  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      detect_cfg_reg <= drgc_pkg::DETECT_CFG_RST;
      timing_reg <= drgc_pkg::TIMING_RST;
      gate_release_reg <= drgc_pkg::GATE_RELEASE_RST;
    end else if (wr_now) begin
      if (hit_cfg) begin
        detect_cfg_reg <= (detect_cfg_reg & ~be_mask) | (AVS_WRITEDATA[15:0] & be_mask);
      end
      if (hit_tim) begin
        timing_reg <= (timing_reg & ~be_mask) | (AVS_WRITEDATA[15:0] & be_mask);
      end
      if (hit_gr) begin
        gate_release_reg <= (gate_release_reg & ~be_mask) | (AVS_WRITEDATA[15:0] & be_mask);
      end
    end
  end

  // field decode
  logic [4:0] activity_rms_threshold;
  logic [1:0] activity_peak_threshold;
  logic gate_en;
  logic activity_detect_sel;
  logic activity_detect_en;
  logic second_knee_out_en;
  logic fast_release_en;
  logic clip_guard_en;
  logic activity_seq_trigger_en;
  logic [3:0] attack_rate;
  logic [3:0] decay_rate;
  logic [2:0] comp_min_code;
  logic [1:0] max_boost_code;
  logic [3:0] gate_min_code;
  logic [1:0] fast_release_threshold;
  logic [1:0] fast_release_rate;

  assign activity_rms_threshold = detect_cfg_reg[drgc_pkg::CFG_RMS_THR_LSB +: 5];
  assign activity_peak_threshold = detect_cfg_reg[drgc_pkg::CFG_PK_THR_LSB +: 2];
  assign gate_en = detect_cfg_reg[drgc_pkg::CFG_GATE_EN];
  assign activity_detect_sel = detect_cfg_reg[drgc_pkg::CFG_DET_SEL];
  assign activity_detect_en = detect_cfg_reg[drgc_pkg::CFG_DET_EN];
  assign second_knee_out_en = detect_cfg_reg[drgc_pkg::CFG_KNEE2_EN];
  assign fast_release_en = detect_cfg_reg[drgc_pkg::CFG_FR_EN];
  assign clip_guard_en = detect_cfg_reg[drgc_pkg::CFG_CLIP_EN];
  assign activity_seq_trigger_en = detect_cfg_reg[drgc_pkg::CFG_SEQ_EN];
  assign attack_rate = timing_reg[drgc_pkg::TIM_ATK_LSB +: 4];
  assign decay_rate = timing_reg[drgc_pkg::TIM_DCY_LSB +: 4];
  assign comp_min_code = timing_reg[drgc_pkg::TIM_MIN_LSB +: 3];
  assign max_boost_code = timing_reg[drgc_pkg::TIM_MAX_LSB +: 2];
  assign gate_min_code = gate_release_reg[drgc_pkg::GR_GATE_MIN_LSB +: 4];
  assign fast_release_threshold = gate_release_reg[drgc_pkg::GR_FR_THR_LSB +: 2];
  assign fast_release_rate = gate_release_reg[drgc_pkg::GR_FR_RATE_LSB +: 2];

  // gain limits in 0.75dB units
  logic signed [8:0] comp_min_gain;
  logic signed [8:0] max_boost_gain;
  logic signed [8:0] gate_min_raw;
  logic signed [8:0] gate_min_gain;
  assign comp_min_gain = drgc_pkg::COMP_MIN_UNITS[comp_min_code];
  assign max_boost_gain = drgc_pkg::MAX_UNITS[max_boost_code];
  assign gate_min_raw = $signed({2'b00, gate_min_code, 3'h0}) + drgc_pkg::GATE_MIN_BASE;
  assign gate_min_gain = (gate_min_raw > drgc_pkg::GAIN_CAP) ? drgc_pkg::GAIN_CAP : gate_min_raw;

  // step periods in clock cycles per 0.75dB; reserved codes pinned to nearest legal
  logic [3:0] atk_code;
  logic [3:0] dcy_code;
  logic [31:0] atk_per;
  logic [31:0] clip_per;
  logic [31:0] dcy_per;
  logic [31:0] fr_per;
  assign atk_code = (attack_rate < drgc_pkg::ATK_CODE_MIN) ? drgc_pkg::ATK_CODE_MIN :
                    (attack_rate > drgc_pkg::ATK_CODE_MAX) ? drgc_pkg::ATK_CODE_MAX : attack_rate;
  assign dcy_code = (decay_rate > drgc_pkg::DCY_CODE_MAX) ? drgc_pkg::DCY_CODE_MAX : decay_rate;
  assign atk_per = 32'(ATK_STEP_CYC) << (atk_code - 4'h1);
  assign clip_per = atk_per >> drgc_pkg::CLIP_SHIFT;
  assign dcy_per = 32'(DCY_STEP_CYC) << dcy_code;
  assign fr_per = (fast_release_rate == 2'h0) ? 32'(FR_STEP_CYC) :
                  (fast_release_rate == 2'h1) ? 32'(FR_STEP_CYC) << 1 : 32'(FR_STEP_CYC) << 3;

  logic valid_reg;
  logic seq_reg;
  logic [7:0] rms_det_thr;
  assign rms_det_thr = {2'h0, activity_rms_threshold, 1'b0} + drgc_pkg::RMS_DET_BASE;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic signed [23:0] x;
    logic ch_en;
    logic [23:0] ax;
    logic [14:0] a15;
    logic [29:0] sq;
    logic signed [32:0] ms_diff;
    logic [31:0] ms_reg;
    logic [31:0] ms_next;
    logic [14:0] pk_reg;
    logic [14:0] pk_next;
    logic [14:0] inst_reg;
    logic [7:0] att_rms;
    logic [7:0] att_pk;
    logic [7:0] att_inst;
    logic signed [8:0] crest;
    logic signed [23:0] dly_reg [drgc_pkg::LOOKAHEAD];
    logic signed [23:0] d;
    logic gated;
    logic fr_act;
    logic clip_trig;
    logic rising;
    logic falling;
    logic stable;
    logic act;
    logic rise;
    logic signed [8:0] raw;
    logic signed [8:0] tgt_pre;
    logic signed [8:0] lo_lim;
    logic signed [8:0] tgt;
    logic signed [8:0] g_app;
    logic signed [7:0] gain_reg;
    logic signed [7:0] gain_next;
    logic signed [8:0] gain9;
    logic [31:0] per;
    logic [31:0] cnt_reg;
    logic step;
    logic clip_reg;
    logic fr_reg;
    logic decay_reg;
    logic gate_reg;
    logic act_reg;
    logic signed [23:0] out_reg;
    logic signed [39:0] prod;
    logic signed [47:0] scaled;
    logic signed [47:0] res;
    logic signed [23:0] sat;
    logic signed [8:0] gi;
    logic [2:0] shamt;

    assign x = (ch == 0) ? IN_LEFT : IN_RIGHT;
    assign ch_en = (ch == 0) ? en_l : en_r;
    assign ax = x[23] ? 24'(-x) : 24'(x);
    assign a15 = ax[23:9];
    assign sq = 30'(a15 * a15);
    // mean square tracker sets the level; peaks only feed crest and clip guard
    assign ms_diff = $signed({3'h0, sq}) - $signed({1'b0, ms_reg});
    assign ms_next = ms_reg + 32'(ms_diff >>> drgc_pkg::RMS_SHIFT);
    assign pk_next = (a15 > pk_reg) ? a15 : pk_reg - (pk_reg >> drgc_pkg::PEAK_SHIFT);
    assign att_rms = att_code({ms_reg[27:0], 4'h0}) >> 1;
    assign att_pk = att_code({pk_reg, 17'h00000});
    assign att_inst = att_code({inst_reg, 17'h00000});
    // peak scale sits one octave below the rms scale
    assign crest = $signed({1'b0, att_rms}) - $signed({1'b0, att_pk}) + 9'(drgc_pkg::UNITS_PER_6DB);
    assign gain9 = {gain_reg[7], gain_reg};

    // static target: level toward a reference, expansion or hard drop when gated
    assign gated = gate_en & (att_rms > drgc_pkg::GATE_ATT);
    assign raw = $signed({1'b0, att_rms}) - drgc_pkg::TARGET_ATT;
    assign tgt_pre = !gated ? raw :
                     second_knee_out_en ? gate_min_gain :
                     raw - $signed({1'b0, att_rms - drgc_pkg::GATE_ATT});
    assign lo_lim = gated ? gate_min_gain : comp_min_gain;
    assign tgt = clamp9(tgt_pre, lo_lim, max_boost_gain);
    assign falling = tgt < gain9;
    assign rising = tgt > gain9;
    assign stable = tgt == gain9;

    assign clip_trig = clip_guard_en & ch_en & ($signed({1'b0, att_inst}) < gain9);
    assign fr_act = fast_release_en & (crest > crest_units(fast_release_threshold));
    assign per = falling ? (clip_trig ? clip_per : atk_per) :
                 fr_act ? fr_per : dcy_per;
    assign step = ch_en & ~stable & (cnt_reg + 32'h1 >= per);
    assign gain_next = !ch_en ? 8'sh00 :
                       !step ? gain_reg :
                       falling ? gain_reg - 8'sh01 : gain_reg + 8'sh01;

    assign act = activity_detect_en & ch_en &
                 (activity_detect_sel ? (att_rms <= rms_det_thr) :
                  (crest > crest_units(activity_peak_threshold)));
    assign rise = act & ~act_reg;

    // lookahead delay only while clip guard is on
    assign d = clip_guard_en ? dly_reg[drgc_pkg::LOOKAHEAD - 1] : x;
    assign g_app = clamp9(gain9, lo_lim, max_boost_gain);
    assign gi = g_app >>> 3;
    assign shamt = gi[8] ? 3'(-gi) : gi[2:0];
    assign prod = 40'(d * $signed({1'b0, drgc_pkg::MANT[g_app[2:0]]}));
    assign scaled = gi[8] ? ($signed({{8{prod[39]}}, prod}) >>> shamt) : ($signed({{8{prod[39]}}, prod}) <<< shamt);
    assign res = scaled >>> drgc_pkg::MANT_FRAC;
    assign sat = (res > 48'sh7fffff) ? 24'sh7fffff :
                 (res < -48'sh800000) ? -24'sh800000 : 24'(res);

    always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        ms_reg <= 32'h0000_0000;
        pk_reg <= 15'h0000;
        inst_reg <= 15'h0000;
        out_reg <= 24'sh000000;
        for (int i = 0; i < drgc_pkg::LOOKAHEAD; i++) begin
          dly_reg[i] <= 24'sh000000;
        end
      end else if (IN_VALID) begin
        ms_reg <= ms_next;
        pk_reg <= pk_next;
        inst_reg <= a15;
        out_reg <= ch_en ? sat : x;
        dly_reg[0] <= x;
        for (int i = 1; i < drgc_pkg::LOOKAHEAD; i++) begin
          dly_reg[i] <= dly_reg[i - 1];
        end
      end
    end

    always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        gain_reg <= 8'sh00;
        cnt_reg <= 32'h0000_0000;
      end else begin
        gain_reg <= gain_next;
        cnt_reg <= (stable || !ch_en || step) ? 32'h0000_0000 : cnt_reg + 32'h1;
      end
    end

    // flags per channel; a fresh trigger beats the stable clear
    always_ff @(posedge CLK or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        clip_reg <= 1'b0;
        fr_reg <= 1'b0;
        decay_reg <= 1'b0;
        gate_reg <= 1'b0;
        act_reg <= 1'b0;
      end else begin
        clip_reg <= ch_en & clip_guard_en & ((clip_trig & falling) | (clip_reg & ~stable));
        fr_reg <= ch_en & fast_release_en & ((fr_act & rising) | (fr_reg & ~stable));
        decay_reg <= ch_en & rising;
        gate_reg <= ch_en & gated;
        act_reg <= act;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      valid_reg <= 1'b0;
      seq_reg <= 1'b0;
    end else begin
      valid_reg <= IN_VALID;
      seq_reg <= activity_seq_trigger_en & (g_ch[0].rise | g_ch[1].rise);
    end
  end

  assign OUT_VALID = valid_reg;
  assign OUT_LEFT = g_ch[0].out_reg;
  assign OUT_RIGHT = g_ch[1].out_reg;
  assign ACTIVITY = {g_ch[1].act_reg, g_ch[0].act_reg};
  assign CLIP_GUARD = {g_ch[1].clip_reg, g_ch[0].clip_reg};
  assign DECAY = {g_ch[1].decay_reg, g_ch[0].decay_reg};
  assign GATE = {g_ch[1].gate_reg, g_ch[0].gate_reg};
  assign FAST_RELEASE = {g_ch[1].fr_reg, g_ch[0].fr_reg};
  assign SEQ_TRIGGER = seq_reg;

endmodule

// >>> core/drgc_unused_placeholder_none.sv
// intentionally empty of logic: no further design files
`timescale 1ns/1ps

// >>> tb/drgc_checker.sv
// port assertions for the stereo gain control stage
`timescale 1ns/1ps
module drgc_checker (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic IN_VALID,
  input wire logic OUT_VALID,
  input wire logic [1:0] ACTIVITY,
  input wire logic [1:0] CLIP_GUARD,
  input wire logic [1:0] DECAY,
  input wire logic [1:0] GATE,
  input wire logic [1:0] FAST_RELEASE,
  input wire logic SEQ_TRIGGER
);
  logic [15:0] cfg_reg;
  wire wr_hit = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[15:2] == drgc_pkg::IDX_DETECT_CFG;
  wire [7:0] hi_byte = AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : cfg_reg[15:8];
  wire [7:0] lo_byte = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : cfg_reg[7:0];
  wire en_l = cfg_reg[drgc_pkg::CFG_EN_LEFT];
  wire en_r = cfg_reg[drgc_pkg::CFG_EN_RIGHT];
  // mirror of the detect config register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_reg <= drgc_pkg::DETECT_CFG_RST;
    end else if (wr_hit) begin
      cfg_reg <= {hi_byte, lo_byte};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_bus_one_wait: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus answer not after one wait state");
  a_out_strobe: assert property (IN_VALID ##1 !IN_VALID |-> OUT_VALID ##1 !OUT_VALID)
    else $error("output strobe not one cycle after input");
  a_left_off_quiet: assert property ((!en_l) [*3] |-> {ACTIVITY[0], CLIP_GUARD[0], DECAY[0], GATE[0], FAST_RELEASE[0]} == 5'h00)
    else $error("left flags set while left disabled");
  a_right_off_quiet: assert property ((!en_r) [*3] |-> {ACTIVITY[1], CLIP_GUARD[1], DECAY[1], GATE[1], FAST_RELEASE[1]} == 5'h00)
    else $error("right flags set while right disabled");
  a_detect_needs_en: assert property ((!cfg_reg[drgc_pkg::CFG_DET_EN]) [*3] |-> ACTIVITY == 2'h0)
    else $error("activity while detect disabled");
  a_gate_needs_en: assert property ((!cfg_reg[drgc_pkg::CFG_GATE_EN]) [*3] |-> GATE == 2'h0)
    else $error("gate flag while gate disabled");
  a_clip_needs_en: assert property ((!cfg_reg[drgc_pkg::CFG_CLIP_EN]) [*3] |-> CLIP_GUARD == 2'h0)
    else $error("clip guard flag while disabled");
  a_fast_needs_en: assert property ((!cfg_reg[drgc_pkg::CFG_FR_EN]) [*3] |-> FAST_RELEASE == 2'h0)
    else $error("fast release flag while disabled");
  a_seq_trig_off: assert property ((!cfg_reg[drgc_pkg::CFG_SEQ_EN]) [*3] |-> !SEQ_TRIGGER)
    else $error("sequencer trigger while disabled");
  a_seq_trig_on: assert property (cfg_reg[drgc_pkg::CFG_SEQ_EN] [*3] ##0 $rose(|ACTIVITY) |-> ##[0:2] SEQ_TRIGGER)
    else $error("no sequencer trigger on detection");
  c_activity: cover property ($rose(|ACTIVITY));
  c_seq: cover property (SEQ_TRIGGER);
  c_gate: cover property ($rose(|GATE));
  c_decay: cover property ($rose(|DECAY));
endmodule

bind drgc_dynamic_range_gain_control drgc_checker u_drgc_checker (.CLK(CLK), .RSTN(RSTN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IN_VALID(IN_VALID),
  .OUT_VALID(OUT_VALID), .ACTIVITY(ACTIVITY), .CLIP_GUARD(CLIP_GUARD), .DECAY(DECAY), .GATE(GATE),
  .FAST_RELEASE(FAST_RELEASE), .SEQ_TRIGGER(SEQ_TRIGGER));

// >>> tb/drgc_mixer_model.sv
// upstream mixer model: square wave or sparse impulses
`timescale 1ns/1ps
module drgc_mixer_model #(
  parameter int PERIOD = 8
) (
  input wire logic clk,
  input wire logic run,
  input wire logic pulse_mode,
  input wire logic [23:0] amp,
  output logic valid = 1'b0,
  output logic signed [23:0] left = 24'sh0,
  output logic signed [23:0] right = 24'sh0
);
  int cnt = 0;
  int idx = 0;
  logic signed [23:0] s;
  always @(posedge clk) begin
    if (run) begin
      cnt <= (cnt + 1) % PERIOD;
    end
    if (run && cnt == 0) begin
      idx <= idx + 1;
      s = (pulse_mode && idx % 64 != 0) ? 24'sh0 : (idx[0] ? -$signed(amp) : $signed(amp));
      valid <= 1'b1;
      left <= s;
      right <= -s;
    end else begin
      valid <= 1'b0;
      // data lines are inverted every cycle between strobes
      left <= ~left;
      right <= ~right;
    end
  end
endmodule

// >>> tb/drgc_dynamic_range_gain_control_tb_top.sv
// self-checking bench for the stereo gain control stage
`timescale 1ns/1ps
module drgc_dynamic_range_gain_control_tb_top;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [15:0] AVS_ADDRESS = 16'h0000;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST, IN_VALID, OUT_VALID, SEQ_TRIGGER;
  logic signed [23:0] IN_LEFT, IN_RIGHT, OUT_LEFT, OUT_RIGHT, last_l, last_r;
  logic [1:0] ACTIVITY, CLIP_GUARD, DECAY, GATE, FAST_RELEASE;
  logic run = 1'b0;
  logic pulse_mode = 1'b0;
  logic [23:0] amp = 24'h000000;
  logic [23:0] loud, quiet;
  logic [15:0] rd, cfg, w;
  logic [3:0] be;
  int n_errors = 0;
  int checks_done = 0;
  int seed = 7;
  int lo = 0;
  int hi = 0;
  int sl = 0;
  int seq_seen = 0;
  logic [15:0] t_cfg [6] = '{16'h00c7, 16'h00c7, 16'h0047, 16'h0047, 16'h0103, 16'h0045};
  logic t_pulse [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic t_loud [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [1:0] t_act [6] = '{2'h3, 2'h0, 2'h3, 2'h0, 2'h0, 2'h2};
  logic [1:0] t_gate [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};

  always #2.5 CLK = ~CLK;

  drgc_dynamic_range_gain_control #(.ATK_STEP_CYC(4), .DCY_STEP_CYC(32), .FR_STEP_CYC(16))
  u_drgc_dynamic_range_gain_control (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IN_VALID(IN_VALID), .IN_LEFT(IN_LEFT), .IN_RIGHT(IN_RIGHT), .OUT_VALID(OUT_VALID),
    .OUT_LEFT(OUT_LEFT), .OUT_RIGHT(OUT_RIGHT), .ACTIVITY(ACTIVITY), .CLIP_GUARD(CLIP_GUARD),
    .DECAY(DECAY), .GATE(GATE), .FAST_RELEASE(FAST_RELEASE), .SEQ_TRIGGER(SEQ_TRIGGER));

  drgc_mixer_model u_drgc_mixer_model (.clk(CLK), .run(run), .pulse_mode(pulse_mode), .amp(amp),
    .valid(IN_VALID), .left(IN_LEFT), .right(IN_RIGHT));

  task automatic bad(input string m);
    n_errors++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic close_out;
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("reg got %h want %h", got, exp));
  endtask

  task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) bad($sformatf("flag got %b want %b", got, exp));
  endtask

  function automatic longint mag(input logic signed [23:0] v);
    return v[23] ? -longint'(v) : longint'(v);
  endfunction

  // output magnitude against input, gain bounds in quarters
  task automatic chk_gain(input logic signed [23:0] o, input logic signed [23:0] i);
    checks_done++;
    if ($isunknown(o) || 4 * mag(o) + sl < lo * mag(i) || 4 * mag(o) > hi * mag(i) + sl)
      bad($sformatf("gain out %0d in %0d", o, i));
  endtask

  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] b);
    return {b[1] ? n[15:8] : o[15:8], b[0] ? n[7:0] : o[7:0]};
  endfunction

  task automatic bus(input logic wr, input logic [13:0] idx, input logic [15:0] wd, input logic [3:0] b,
                     output logic [15:0] q);
    int k;
    @(posedge CLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= {16'h0000, wd};
    AVS_BYTEENABLE <= b;
    for (k = 0; k < 40; k++) begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    q = AVS_READDATA[15:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (k == 40) begin
      bad("bus timeout");
      close_out;
    end
  endtask

  task automatic wait_flags(input logic [1:0] ea, input logic [1:0] eg);
    for (int k = 0; k < 8000; k++) begin
      @(negedge CLK);
      if (ACTIVITY === ea && GATE === eg) break;
    end
    repeat (1000) @(negedge CLK);
    chk_flag(ACTIVITY, ea);
    chk_flag(GATE, eg);
  endtask

  always @(negedge CLK) begin
    if (IN_VALID === 1'b1) begin
      last_l <= IN_LEFT;
      last_r <= IN_RIGHT;
    end
    if (SEQ_TRIGGER === 1'b1) seq_seen <= seq_seen + 1;
    if (OUT_VALID === 1'b1 && hi > 0) begin
      chk_gain(OUT_LEFT, last_l);
      chk_gain(OUT_RIGHT, last_r);
    end
  end

  initial begin
    repeat (95000) @(posedge CLK);
    bad("run timeout");
    close_out;
  end

  initial begin
    loud = 24'd3000000 + 24'($random(seed) & 32'h000fffff);
    quiet = 24'd200 + 24'($random(seed) & 32'h000003ff);
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    bus(1'b0, drgc_pkg::IDX_DETECT_CFG, 16'h0000, 4'h3, rd);
    chk_reg(rd, 16'h0018);
    bus(1'b0, drgc_pkg::IDX_TIMING, 16'h0000, 4'h3, rd);
    chk_reg(rd, {3'h0, 4'b0100, 4'b1001, 3'b100, 2'b11});
    bus(1'b0, drgc_pkg::IDX_GATE_RELEASE, 16'h0000, 4'h3, rd);
    chk_reg(rd, 16'h0000);
    cfg = 16'h0018;
    for (int i = 0; i < 6; i++) begin
      w = 16'($random(seed));
      be = 4'($random(seed));
      bus(1'b1, drgc_pkg::IDX_DETECT_CFG, w, be, rd);
      cfg = merge(cfg, w, be[1:0]);
      bus(1'b0, drgc_pkg::IDX_DETECT_CFG, 16'h0000, 4'h3, rd);
      chk_reg(rd, cfg);
      bus(1'b0, drgc_pkg::IDX_PATH_STATUS, 16'h0000, 4'h3, rd);
      chk_reg(rd, {6'h00, cfg[0], cfg[1], 8'h00});
    end
    bus(1'b1, drgc_pkg::IDX_PATH_STATUS, 16'hffff, 4'hf, rd);
    bus(1'b0, drgc_pkg::IDX_PATH_STATUS, 16'h0000, 4'h3, rd);
    chk_reg(rd, {6'h00, cfg[0], cfg[1], 8'h00});
    bus(1'b1, 14'h0e90, 16'hffff, 4'hf, rd);
    bus(1'b0, 14'h0e90, 16'h0000, 4'h3, rd);
    chk_reg(rd, 16'h0000);
    // both channels off, no lookahead: audio passes untouched
    bus(1'b1, drgc_pkg::IDX_DETECT_CFG, 16'h0000, 4'h3, rd);
    amp <= loud;
    lo = 4;
    hi = 4;
    run <= 1'b1;
    repeat (400) @(posedge CLK);
    chk_flag(ACTIVITY | CLIP_GUARD | DECAY | GATE | FAST_RELEASE, 2'h0);
    hi = 0;
    // fast rates, min gain 0dB, max boost 12dB, no lookahead
    bus(1'b1, drgc_pkg::IDX_TIMING, 16'h0200, 4'h3, rd);
    amp <= quiet;
    bus(1'b1, drgc_pkg::IDX_DETECT_CFG, 16'h0003, 4'h3, rd);
    lo = 4;
    hi = 16;
    sl = 8;
    for (int k = 0; k < 3000; k++) begin
      @(negedge CLK);
      if (DECAY === 2'h3) break;
    end
    chk_flag(DECAY, 2'h3);
    repeat (3000) @(posedge CLK);
    lo = 12;
    repeat (500) @(posedge CLK);
    lo = 4;
    amp <= loud;
    repeat (2000) @(posedge CLK);
    hi = 5;
    repeat (500) @(posedge CLK);
    hi = 0;
    for (int c = 0; c < 6; c++) begin
      bus(1'b1, drgc_pkg::IDX_DETECT_CFG, t_cfg[c], 4'h3, rd);
      pulse_mode <= t_pulse[c];
      amp <= t_loud[c] ? loud : quiet;
      wait_flags(t_act[c], t_gate[c]);
    end
    chk_flag({1'b0, seq_seen > 0}, 2'h1);
    close_out;
  end
endmodule
